// ===== omps_sequencer.sv
// Functional notes
// - Mute decisions come only from one monitored supply rail level.
// - Relays stay engaged from power-up until rail exceeds 81 percent nominal.
// - Above upper threshold, wait one second, then release the relays.
// - Below 79 percent nominal, engage relays at once, no delay.
// - Mute applies jointly to control room A, B and studio pairs.
`timescale 1ns/1ps
module omps_sequencer
    import omps_pkg::*;
#(
    parameter int unsigned RAIL_WIDTH = RAIL_W,
    parameter logic [RAIL_WIDTH-1:0] NOMINAL = NOMINAL_CODE,
    parameter int unsigned DELAY_CYCLES = QUAL_CYCLES
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [RAIL_WIDTH-1:0] rail_level_i,
    output omps_mute_type mute_o,
    output logic released_o
);

    // ------------------------------------------------------------
    // Thresholds
    // ------------------------------------------------------------
    // Widened product avoids overflow of nominal times percent
    localparam logic [RAIL_WIDTH+7:0] UPPER_LIM =
        (RAIL_WIDTH+8)'((int'(NOMINAL) * UPPER_PCT) / PCT_FULL);
    localparam logic [RAIL_WIDTH+7:0] LOWER_LIM =
        (RAIL_WIDTH+8)'((int'(NOMINAL) * LOWER_PCT) / PCT_FULL);
    localparam int unsigned CNT_W = $clog2(DELAY_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DELAY_CYCLES - 1);

    logic above_upper;
    logic below_lower;
    omps_state_type state;
    omps_state_type next_state;
    logic [CNT_W-1:0] count;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // One decode feeds every relay so the three pairs cannot drift apart
    function automatic logic mute_for(input omps_state_type st);
        return st != OMPS_RUN;
    endfunction : mute_for

    assign above_upper = {8'h00, rail_level_i} > UPPER_LIM;
    assign below_lower = {8'h00, rail_level_i} < LOWER_LIM;

    // ------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            OMPS_MUTED: begin
                if (above_upper) begin
                    next_state = OMPS_QUALIFY;
                end
            end
            OMPS_QUALIFY: begin
                if (below_lower) begin
                    next_state = OMPS_MUTED;
                end else if (count == CNT_LAST) begin
                    next_state = OMPS_RUN;
                end
            end
            OMPS_RUN: begin
                if (below_lower) begin
                    next_state = OMPS_MUTED;
                end
            end
            default: begin
                next_state = OMPS_MUTED;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= OMPS_MUTED;
        end else begin
            state <= next_state;
        end
    end

    // Counter clears outside the delay so a retry starts from zero
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count <= '0;
        end else if (state == OMPS_QUALIFY && next_state == OMPS_QUALIFY) begin
            count <= count + CNT_W'(1);
        end else begin
            count <= '0;
        end
    end

    // ------------------------------------------------------------
    // Relay drive
    // ------------------------------------------------------------
    // Registered from next_state so relays see no combinational glitches and do not lag the state
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mute_o <= '{MUTE_RST, MUTE_RST, MUTE_RST};
        end else begin
            mute_o.cr_a <= mute_for(next_state);
            mute_o.cr_b <= mute_for(next_state);
            mute_o.studio <= mute_for(next_state);
        end
    end

    // Status flag follows the same decode, so it never leads the relays
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            released_o <= 1'b0;
        end else begin
            released_o <= !mute_for(next_state);
        end
    end

    // ------------------------------------------------------------
    // Check helpers
    // ------------------------------------------------------------
    // Separate tallies, so a slip in the sequencing counter cannot hide itself
    logic [CNT_W:0] since_high;
    logic [1:0] low_streak;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            since_high <= '0;
        end else if (state == OMPS_MUTED) begin
            since_high <= '0;
        end else if (since_high != '1) begin
            since_high <= since_high + (CNT_W+1)'(1);
        end
    end

    // Saturates at three; only zero against nonzero matters
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            low_streak <= '0;
        end else if (!below_lower) begin
            low_streak <= '0;
        end else if (low_streak != 2'h3) begin
            low_streak <= low_streak + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_mute_joint: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (mute_o.cr_a == mute_o.cr_b) && (mute_o.cr_b == mute_o.studio))
        else $error("Mute outputs disagree");

    a_fast_mute: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (!mute_o.cr_a && below_lower) |=> mute_o.cr_a)
        else $error("Mute not engaged one cycle after low rail");

    a_low_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (state == OMPS_MUTED && !above_upper) |=> mute_o.cr_a)
        else $error("Released without rail above upper threshold");

    a_delay_full: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        $rose(state == OMPS_RUN) |-> $past(count) == CNT_LAST)
        else $error("Release before full qualification delay");

    a_hold_between: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (state == OMPS_RUN && !below_lower) |=> state == OMPS_RUN)
        else $error("Run state left without low rail");

    a_abort_restart: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (state == OMPS_QUALIFY && below_lower) |=> (state == OMPS_MUTED && count == '0))
        else $error("Delay not abandoned on low rail");

    a_release_out: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        $rose(state == OMPS_RUN) |-> (!mute_o.cr_a && released_o))
        else $error("Relays not released at end of delay");

    a_rail_only: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (state == OMPS_MUTED && above_upper) |=> state == OMPS_QUALIFY)
        else $error("Qualification not started on high rail");

    a_reset_mute: assert property (@(posedge clk_i)
        !arst_n_i |=> (mute_o.cr_a && mute_o.cr_b && mute_o.studio && !released_o))
        else $error("Relays not engaged around reset");

    a_qualify_muted: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (state == OMPS_QUALIFY) |-> (mute_o.cr_a && !released_o))
        else $error("Relays released during qualification delay");

    a_count_idle: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (state != OMPS_QUALIFY) |-> (count == '0))
        else $error("Delay count not cleared outside qualification");

    a_count_step: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (state == OMPS_QUALIFY && !below_lower && count != CNT_LAST) |=>
        (count == $past(count) + CNT_W'(1)))
        else $error("Delay count skipped a cycle");

    a_no_early_run: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (state != OMPS_RUN && !(state == OMPS_QUALIFY && count == CNT_LAST)) |=>
        (state != OMPS_RUN))
        else $error("Run entered without full delay");

    a_run_to_mute: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        $fell(state == OMPS_RUN) |->
        (mute_o.cr_a && mute_o.cr_b && mute_o.studio && !released_o))
        else $error("Relays not engaged on leaving run");

    a_release_time: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        $rose(released_o) |-> (since_high == (CNT_W+1)'(DELAY_CYCLES)))
        else $error("Release not one full delay after high rail");

    a_low_streak: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (low_streak != 2'h0) |-> (mute_o.cr_a && mute_o.cr_b && mute_o.studio))
        else $error("Relays open while rail is low");

    a_hold_muted: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (state == OMPS_MUTED && !above_upper) |=> (state == OMPS_MUTED))
        else $error("Muted state left without high rail");

    a_state_legal: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (state == OMPS_MUTED) || (state == OMPS_QUALIFY) || (state == OMPS_RUN))
        else $error("Sequencer in undefined state");

endmodule : omps_sequencer

// ===== omps_pkg.sv
package omps_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned QUAL_DELAY_MS = 1000;
    localparam int unsigned QUAL_CYCLES = (QUAL_DELAY_MS * 1000000) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Thresholds, percent of nominal
    // ------------------------------------------------------------
    localparam int unsigned UPPER_PCT = 81;
    localparam int unsigned LOWER_PCT = 79;
    localparam int unsigned PCT_FULL = 100;
    localparam int unsigned RAIL_W = 12;
    localparam logic [RAIL_W-1:0] NOMINAL_CODE = 12'hC00;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic MUTE_RST = 1'b1;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        OMPS_MUTED = 2'b00,
        OMPS_QUALIFY = 2'b01,
        OMPS_RUN = 2'b10
    } omps_state_type;

    typedef struct packed {
        logic cr_a;
        logic cr_b;
        logic studio;
    } omps_mute_type;

endpackage : omps_pkg

// ===== omps_rail_model.sv
`timescale 1ns/1ps
module omps_rail_model
    import omps_pkg::*;
(
    input wire logic [RAIL_W-1:0] target_i,
    output logic [RAIL_W-1:0] rail_level_o
);
    // Ideal monitor, no noise; the bench steps it at falling edges
    assign rail_level_o = target_i;
endmodule : omps_rail_model

// ===== test_output_mute_power_sequencer.sv
`timescale 1ns/1ps
module test_output_mute_power_sequencer
    import omps_pkg::*;
;
    // --------------------------------
    // Setup
    // --------------------------------
    localparam int unsigned DLY = 20;
    localparam int unsigned UP = NOMINAL_CODE * UPPER_PCT / PCT_FULL;
    localparam int unsigned LO = NOMINAL_CODE * LOWER_PCT / PCT_FULL;
    localparam logic [3:0] MUTED = 4'hE;
    localparam logic [3:0] FREE = 4'h1;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [RAIL_W-1:0] target = '0;
    wire logic [RAIL_W-1:0] rail;
    omps_mute_type mute;
    logic released;
    int bad_count = 0;
    int checks = 0;
    always #5 clk = ~clk;
    omps_rail_model i_omps_rail_model (.target_i(target), .rail_level_o(rail));
    omps_sequencer #(.DELAY_CYCLES(DLY)) i_omps_sequencer (.clk_i(clk), .arst_n_i(arst_n),
        .rail_level_i(rail), .mute_o(mute), .released_o(released));
    // --------------------------------
    // Tasks
    // --------------------------------
    task automatic chk(input logic [3:0] exp);
        checks++;
        if ({mute, released} !== exp) begin
            bad_count++;
            $display("[FAIL] %0t outputs %b expected %b", $time, {mute, released}, exp);
        end
    endtask : chk
    task automatic set_rail(input int unsigned v);
        @(negedge clk);
        target = RAIL_W'(v);
    endtask : set_rail
    task automatic wait_chk(input int n, input logic [3:0] exp);
        repeat (n) @(posedge clk);
        #1;
        chk(exp);
    endtask : wait_chk
    task automatic t_power_up;
        repeat (8) @(negedge clk);
        chk(MUTED);
        arst_n = 1'b1;
        set_rail(UP);
        wait_chk(30, MUTED);
        $display("power up done");
    endtask : t_power_up
    task automatic t_release;
        set_rail(UP + 1);
        @(posedge clk);
        // Between thresholds must not disturb the count
        set_rail(LO);
        wait_chk(DLY - 1, MUTED);
        wait_chk(1, FREE);
        $display("release done");
    endtask : t_release
    task automatic t_hold_drop;
        wait_chk(10, FREE);
        set_rail(LO - 1);
        wait_chk(1, MUTED);
        $display("drop done");
    endtask : t_hold_drop
    task automatic t_abort;
        set_rail(UP + 1);
        repeat (10) @(posedge clk);
        set_rail(LO - 1);
        wait_chk(1, MUTED);
        set_rail(LO);
        wait_chk(DLY, MUTED);
        t_release();
        $display("abort done");
    endtask : t_abort
    task automatic t_reset_mid;
        set_rail(UP + 1);
        wait_chk(DLY + 1, FREE);
        @(negedge clk);
        arst_n = 1'b0;
        #1;
        chk(MUTED);
        repeat (2) @(negedge clk);
        arst_n = 1'b1;
        wait_chk(DLY, MUTED);
        wait_chk(1, FREE);
        $display("reset done");
    endtask : t_reset_mid
    task automatic end_of_test;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    // --------------------------------
    // Sequence
    // --------------------------------
    initial begin
        t_power_up();
        t_release();
        t_hold_drop();
        t_abort();
        t_reset_mid();
        end_of_test();
    end
    initial begin
        #(400 * DLY * 10);
        bad_count++;
        end_of_test();
    end
endmodule : test_output_mute_power_sequencer
